// ==== pkg/brc_pkg.sv ====
// Constants for the board reset and slave configuration register bank
package brc_pkg;

  // Register indices on host address lines A29..A31; byte offset = index * 4
  localparam logic [2:0] BRC_IDX_RST_CTRL  = 3'h1;
  localparam logic [2:0] BRC_IDX_CFG_CTRL  = 3'h2;
  localparam logic [2:0] BRC_IDX_CLK_BOOT  = 3'h3;
  localparam logic [7:0] BRC_OFS_RST_CTRL  = 8'h04;
  localparam logic [7:0] BRC_OFS_CFG_CTRL  = 8'h08;
  localparam logic [7:0] BRC_OFS_CLK_BOOT  = 8'h0c;

  // slave_reset_control fields
  localparam int BRC_RC_SLAVE_RECONFIG_REQUEST   = 0;
  localparam int BRC_RC_OFFBOARD_SLAVE1_HARD_RESET    = 1;
  localparam int BRC_RC_OFFBOARD_SLAVE2_HARD_RESET    = 2;
  localparam int BRC_RC_SPARE    = 3;
  localparam int BRC_RC_OFFBOARD_SLAVE3_HARD_RESET    = 4;
  localparam int BRC_RC_PHY_RST  = 5;
  localparam int BRC_RC_HOST_SER = 6;
  localparam int BRC_RC_SLV_UART = 7;

  // slave_config_control fields
  localparam int BRC_CC_RSTCFG   = 0;
  localparam int BRC_CC_SOURCE   = 1;
  localparam int BRC_CC_WDOG     = 2;
  localparam int BRC_CC_WIDTH    = 3;
  localparam int BRC_CC_SYNC     = 4;
  localparam int BRC_CC_HARD     = 5;
  localparam int BRC_CC_SOFT     = 6;
  localparam int BRC_CC_FRAMER   = 7;

  // slave_clock_boot_config fields
  localparam int BRC_CB_CLK_LSB  = 0;
  localparam int BRC_CB_DEBUG    = 2;
  localparam int BRC_CB_BOOT_LSB = 5;

  // Reset values
  localparam logic [7:0] BRC_RST_CTRL_DEFAULT = 8'h7f;
  localparam logic [7:0] BRC_CFG_CTRL_BASE    = 8'he0;
  localparam logic [7:0] BRC_CLK_BOOT_SPARE   = 8'h18;
  localparam logic [2:0] BRC_BOOT_SWITCH_ON   = 3'h4;
  localparam logic [2:0] BRC_BOOT_SWITCH_OFF  = 3'h0;
  localparam logic [7:0] BRC_UNMAPPED_READ    = 8'hff;

  // Timing
  localparam int BRC_CLK_PERIOD_NS  = 40;
  localparam int BRC_REQ_TIME_NS    = 1000;
  localparam int BRC_HOLD_TIME_NS   = 400;
  localparam int BRC_DEBUG_PULSE_NS = 200;

  function automatic int brc_ns_to_cycles(input int ns);
    int c;
    c = (ns + BRC_CLK_PERIOD_NS - 1) / BRC_CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : brc_ns_to_cycles

  localparam int BRC_REQ_CYCLES   = brc_ns_to_cycles(BRC_REQ_TIME_NS);
  localparam int BRC_HOLD_CYCLES  = brc_ns_to_cycles(BRC_HOLD_TIME_NS);
  localparam int BRC_DEBUG_CYCLES = brc_ns_to_cycles(BRC_DEBUG_PULSE_NS);

  typedef enum logic [1:0] {
    BRC_CFG_IDLE,
    BRC_CFG_REQ,
    BRC_CFG_HOLD
  } brc_cfg_state_t;

endpackage : brc_pkg

// ==== hw/brc_pin_drive.sv ====
// Registered three-state drivers for pins that float outside a drive window
`timescale 1ns/1ns
module brc_pin_drive
  import brc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys_in,
  input  wire logic             sys_rst_in,
  input  wire logic             ce_in,
  input  wire logic             drive_in,
  input  wire logic [WIDTH-1:0] value_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe_n_out
);

  if (WIDTH < 1) begin : g_bad_width
    $error("brc_pin_drive: WIDTH must be at least 1");
  end

  // Released after reset; the owner opens the window explicitly
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pin_out      <= '0;
      pin_oe_n_out <= '1;
    end else if (ce_in) begin
      pin_out      <= value_in;
      pin_oe_n_out <= {WIDTH{~drive_in}};
    end
  end

endmodule : brc_pin_drive

// ==== hw/brc_pulse.sv ====
// Fixed-length positive pulse on a shared pin, released between pulses
`timescale 1ns/1ns
module brc_pulse
  import brc_pkg::*;
#(
  parameter int PULSE_CYCLES = BRC_DEBUG_CYCLES
) (
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  input  wire logic ce_in,
  input  wire logic fire_in,
  output logic      pin_out,
  output logic      pin_oe_n_out
);

  if (PULSE_CYCLES < 1 || PULSE_CYCLES > 255) begin : g_bad_len
    $error("brc_pulse: PULSE_CYCLES must be 1..255");
  end

  logic [7:0] count_reg;

  // A new request restarts the pulse rather than stacking
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      count_reg <= 8'h00;
    end else if (ce_in) begin
      if (fire_in) begin
        count_reg <= 8'(PULSE_CYCLES);
      end else if (count_reg != 8'h00) begin
        count_reg <= count_reg - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pin_out      <= 1'b0;
      pin_oe_n_out <= 1'b1;
    end else if (ce_in) begin
      pin_out      <= fire_in || (count_reg > 8'h01);
      pin_oe_n_out <= ~(fire_in || (count_reg > 8'h01));
    end
  end

endmodule : brc_pulse

// ==== hw/brc_regs.sv ====
// Board reset, transceiver and slave configuration registers on the host bus
`timescale 1ns/1ns
module brc_regs
  import brc_pkg::*;
#(
  parameter int REQ_CYCLES   = BRC_REQ_CYCLES,
  parameter int HOLD_CYCLES  = BRC_HOLD_CYCLES,
  parameter int DEBUG_CYCLES = BRC_DEBUG_CYCLES
) (
  input  wire logic       clk_sys_in,
  input  wire logic       sys_rst_in,
  input  wire logic       ce_in,
  // Host byte bus
  input  wire logic       cs_n_in,
  input  wire logic       rd_wr_in,
  input  wire logic [2:0] addr_in,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe_n_out,
  output logic            ta_n_out,
  // Host hard reset and board switches
  input  wire logic       hard_reset_line_n_in,
  input  wire logic       cfg_switch_on_in,
  input  wire logic [1:0] clock_mode_switch_in,
  input  wire logic       host_if_width_switch_in,
  // Open-drain reset lines to the slaves
  input  wire logic [2:0] offboard_slave_hard_reset_in,
  output logic      [2:0] offboard_slave_hard_reset_out,
  output logic      [2:0] offboard_slave_hard_reset_oe_n_out,
  input  wire logic       onboard_slave_hard_reset_in,
  output logic            onboard_slave_hard_reset_out,
  output logic            onboard_slave_hard_reset_oe_n_out,
  input  wire logic       onboard_slave_soft_reset_in,
  output logic            onboard_slave_soft_reset_out,
  output logic            onboard_slave_soft_reset_oe_n_out,
  // Peripheral controls
  output logic            host_phy_reset_n_out,
  output logic            host_serial_xcvr_enable_n_out,
  output logic            slave_uart_xcvr_enable_n_out,
  output logic            framer_route_select_out,
  // Slave configuration inputs
  output logic            slave_config_request_line_n_out,
  output logic            slave_reset_config_mode_out,
  output logic            slave_config_source_out,
  output logic            slave_config_source_oe_n_out,
  output logic            slave_watchdog_enable_out,
  output logic            slave_watchdog_enable_oe_n_out,
  output logic            host_if_sync_mode_out,
  output logic            host_if_sync_mode_oe_n_out,
  output logic      [1:0] slave_clock_mode_out,
  output logic      [1:0] slave_clock_mode_oe_n_out,
  output logic      [2:0] slave_boot_mode_out,
  output logic      [2:0] slave_boot_mode_oe_n_out,
  // Debug request pin
  input  wire logic       slave_debug_input_in,
  output logic            slave_debug_input_out,
  output logic            slave_debug_input_oe_n_out
);

  if (REQ_CYCLES < 1 || REQ_CYCLES > 65535) begin : g_bad_req
    $error("brc_regs: REQ_CYCLES must be 1..65535");
  end
  if (HOLD_CYCLES < 1 || HOLD_CYCLES > 65535) begin : g_bad_hold
    $error("brc_regs: HOLD_CYCLES must be 1..65535");
  end

  logic [7:0]     rst_ctrl_reg;
  logic [7:0]     cfg_ctrl_reg;
  logic [7:0]     clk_boot_reg;
  logic           width_latch_reg;
  logic           post_rst_reg;
  logic           busy_reg;
  brc_cfg_state_t cfg_state_reg;
  brc_cfg_state_t cfg_state_next;
  logic [15:0]    cfg_count_reg;
  logic [15:0]    cfg_count_next;

  logic           access;
  logic           wr_access;
  logic           reload;
  logic           slave_reconfig_request_req;
  logic           debug_req;
  logic [7:0]     read_value;
  logic [7:0]     cfg_default;
  logic [7:0]     clk_boot_default;
  logic [7:0]     pin_value;
  logic [7:0]     pin_out;
  logic [7:0]     pin_oe_n;

  // Merge a byte write, leaving fixed bits untouched
  function automatic logic [7:0] brc_merge(input logic [7:0] old_v,
                                           input logic [7:0] new_v,
                                           input logic [7:0] wmask);
    return (old_v & ~wmask) | (new_v & wmask);
  endfunction : brc_merge

  // Decode is on the low three address lines only, so every register repeats
  // throughout the chip-select region
  function automatic logic brc_hit(input logic [2:0] a, input logic [2:0] idx);
    return a == idx;
  endfunction : brc_hit

  // One access per chip-select assertion; the host must release cs between
  assign access    = ce_in && !cs_n_in && !busy_reg;
  assign wr_access = access && !rd_wr_in;
  // Host hard reset reloads defaults just like main power-on
  assign reload    = !hard_reset_line_n_in;

  assign slave_reconfig_request_req = wr_access && brc_hit(addr_in, BRC_IDX_RST_CTRL)
                      && !data_in[BRC_RC_SLAVE_RECONFIG_REQUEST];
  assign debug_req  = wr_access && brc_hit(addr_in, BRC_IDX_CLK_BOOT)
                      && !data_in[BRC_CB_DEBUG];

  // Switch-dependent defaults: source and watchdog are 0 with switch on
  always_comb begin
    cfg_default = BRC_CFG_CTRL_BASE;
    cfg_default[BRC_CC_SOURCE] = !cfg_switch_on_in;
    cfg_default[BRC_CC_WDOG]   = !cfg_switch_on_in;
    cfg_default[BRC_CC_WIDTH]  = 1'b0;
  end

  always_comb begin
    clk_boot_default = BRC_CLK_BOOT_SPARE;
    clk_boot_default[BRC_CB_CLK_LSB +: 2] = clock_mode_switch_in;
    clk_boot_default[BRC_CB_DEBUG] = 1'b1;
    clk_boot_default[BRC_CB_BOOT_LSB +: 3] = cfg_switch_on_in ? BRC_BOOT_SWITCH_ON
                                                              : BRC_BOOT_SWITCH_OFF;
  end

  // Width switch is caught only at main power-on, not on host hard reset
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      width_latch_reg <= host_if_width_switch_in;
    end
  end

  // Slave reset control; bit 0 and bit 3 hold no state and stay at one
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rst_ctrl_reg <= BRC_RST_CTRL_DEFAULT;
    end else if (ce_in) begin
      if (reload) begin
        rst_ctrl_reg <= BRC_RST_CTRL_DEFAULT;
      end else if (wr_access && brc_hit(addr_in, BRC_IDX_RST_CTRL)) begin
        rst_ctrl_reg <= brc_merge(rst_ctrl_reg, data_in, 8'hf6);
      end
    end
  end

  // Slave configuration control; width bit is read-only
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cfg_ctrl_reg <= BRC_CFG_CTRL_BASE;
      cfg_ctrl_reg[BRC_CC_SOURCE] <= 1'b1;
      cfg_ctrl_reg[BRC_CC_WDOG]   <= 1'b1;
    end else if (ce_in) begin
      if (reload || post_rst_reg) begin
        cfg_ctrl_reg <= cfg_default;
      end else if (wr_access && brc_hit(addr_in, BRC_IDX_CFG_CTRL)) begin
        cfg_ctrl_reg <= brc_merge(cfg_ctrl_reg, data_in, 8'hf7);
      end
    end
  end

  // Straps are not valid during sys reset, so the first edge after release
  // loads the switch-based defaults
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      post_rst_reg <= 1'b1;
    end else if (ce_in) begin
      post_rst_reg <= 1'b0;
    end
  end

  // Clock/boot configuration; debug bit and bits 3-4 hold no state
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      clk_boot_reg <= BRC_CLK_BOOT_SPARE;
    end else if (ce_in) begin
      if (reload || post_rst_reg) begin
        clk_boot_reg <= clk_boot_default;
      end else if (wr_access && brc_hit(addr_in, BRC_IDX_CLK_BOOT)) begin
        clk_boot_reg <= brc_merge(clk_boot_reg, data_in, 8'he3);
      end
    end
  end

  // Configuration sequence: request line low, then pins held, then released
  always_comb begin
    cfg_state_next = cfg_state_reg;
    cfg_count_next = cfg_count_reg;
    case (cfg_state_reg)
      BRC_CFG_IDLE: begin
        cfg_count_next = 16'h0000;
      end
      BRC_CFG_REQ: begin
        if (cfg_count_reg == 16'h0001) begin
          cfg_state_next = BRC_CFG_HOLD;
          cfg_count_next = 16'(HOLD_CYCLES);
        end else begin
          cfg_count_next = cfg_count_reg - 16'h0001;
        end
      end
      BRC_CFG_HOLD: begin
        if (cfg_count_reg == 16'h0001) begin
          cfg_state_next = BRC_CFG_IDLE;
          cfg_count_next = 16'h0000;
        end else begin
          cfg_count_next = cfg_count_reg - 16'h0001;
        end
      end
      default: begin
        cfg_state_next = BRC_CFG_IDLE;
        cfg_count_next = 16'h0000;
      end
    endcase
    // A new request restarts the sequence from the request phase
    if (slave_reconfig_request_req || post_rst_reg) begin
      cfg_state_next = BRC_CFG_REQ;
      cfg_count_next = 16'(REQ_CYCLES);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cfg_state_reg <= BRC_CFG_IDLE;
      cfg_count_reg <= 16'h0000;
    end else if (ce_in) begin
      cfg_state_reg <= cfg_state_next;
      cfg_count_reg <= cfg_count_next;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      slave_config_request_line_n_out <= 1'b1;
    end else if (ce_in) begin
      slave_config_request_line_n_out <= cfg_state_next != BRC_CFG_REQ;
    end
  end

  // Config pins: source, watchdog, sync, clock mode and boot mode
  always_comb begin
    pin_value[0]   = cfg_ctrl_reg[BRC_CC_SOURCE];
    pin_value[1]   = cfg_ctrl_reg[BRC_CC_WDOG];
    pin_value[2]   = cfg_ctrl_reg[BRC_CC_SYNC];
    pin_value[4:3] = clk_boot_reg[BRC_CB_CLK_LSB +: 2];
    pin_value[7:5] = clk_boot_reg[BRC_CB_BOOT_LSB +: 3];
  end

  brc_pin_drive #(
    .WIDTH (8)
  ) u_cfg_pins (
    .clk_sys_in   (clk_sys_in),
    .sys_rst_in   (sys_rst_in),
    .ce_in        (ce_in),
    .drive_in     (cfg_state_next != BRC_CFG_IDLE),
    .value_in     (pin_value),
    .pin_out      (pin_out),
    .pin_oe_n_out (pin_oe_n)
  );

  assign slave_config_source_out        = pin_out[0];
  assign slave_config_source_oe_n_out   = pin_oe_n[0];
  assign slave_watchdog_enable_out      = pin_out[1];
  assign slave_watchdog_enable_oe_n_out = pin_oe_n[1];
  assign host_if_sync_mode_out          = pin_out[2];
  assign host_if_sync_mode_oe_n_out     = pin_oe_n[2];
  assign slave_clock_mode_out           = pin_out[4:3];
  assign slave_clock_mode_oe_n_out      = pin_oe_n[4:3];
  assign slave_boot_mode_out            = pin_out[7:5];
  assign slave_boot_mode_oe_n_out       = pin_oe_n[7:5];

  brc_pulse #(
    .PULSE_CYCLES (DEBUG_CYCLES)
  ) u_debug (
    .clk_sys_in   (clk_sys_in),
    .sys_rst_in   (sys_rst_in),
    .ce_in        (ce_in),
    .fire_in      (debug_req),
    .pin_out      (slave_debug_input_out),
    .pin_oe_n_out (slave_debug_input_oe_n_out)
  );

  // Reset lines are pulled low only while their bit is zero
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      offboard_slave_hard_reset_out      <= 3'h0;
      offboard_slave_hard_reset_oe_n_out <= 3'h7;
      onboard_slave_hard_reset_out       <= 1'b0;
      onboard_slave_hard_reset_oe_n_out  <= 1'b1;
      onboard_slave_soft_reset_out       <= 1'b0;
      onboard_slave_soft_reset_oe_n_out  <= 1'b1;
    end else if (ce_in) begin
      offboard_slave_hard_reset_oe_n_out <= {rst_ctrl_reg[BRC_RC_OFFBOARD_SLAVE3_HARD_RESET],
                                             rst_ctrl_reg[BRC_RC_OFFBOARD_SLAVE2_HARD_RESET],
                                             rst_ctrl_reg[BRC_RC_OFFBOARD_SLAVE1_HARD_RESET]};
      onboard_slave_hard_reset_oe_n_out  <= cfg_ctrl_reg[BRC_CC_HARD];
      onboard_slave_soft_reset_oe_n_out  <= cfg_ctrl_reg[BRC_CC_SOFT];
    end
  end

  // Peripheral control lines
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      host_phy_reset_n_out          <= 1'b0;
      host_serial_xcvr_enable_n_out <= 1'b1;
      slave_uart_xcvr_enable_n_out  <= 1'b0;
      framer_route_select_out       <= 1'b1;
      slave_reset_config_mode_out   <= 1'b0;
    end else if (ce_in) begin
      host_phy_reset_n_out          <= rst_ctrl_reg[BRC_RC_PHY_RST]
                                       && hard_reset_line_n_in;
      host_serial_xcvr_enable_n_out <= rst_ctrl_reg[BRC_RC_HOST_SER];
      slave_uart_xcvr_enable_n_out  <= rst_ctrl_reg[BRC_RC_SLV_UART];
      framer_route_select_out       <= cfg_ctrl_reg[BRC_CC_FRAMER];
      // Reset-config input stays driven; it has no float phase
      slave_reset_config_mode_out   <= cfg_ctrl_reg[BRC_CC_RSTCFG];
    end
  end

  // Read mux: slave reset bits show the sampled lines, not the stored bits
  always_comb begin
    read_value = BRC_UNMAPPED_READ;
    case (addr_in)
      BRC_IDX_RST_CTRL: begin
        read_value = rst_ctrl_reg;
        read_value[BRC_RC_OFFBOARD_SLAVE1_HARD_RESET] = offboard_slave_hard_reset_in[0];
        read_value[BRC_RC_OFFBOARD_SLAVE2_HARD_RESET] = offboard_slave_hard_reset_in[1];
        read_value[BRC_RC_OFFBOARD_SLAVE3_HARD_RESET] = offboard_slave_hard_reset_in[2];
      end
      BRC_IDX_CFG_CTRL: begin
        read_value = cfg_ctrl_reg;
        read_value[BRC_CC_WIDTH] = width_latch_reg;
        read_value[BRC_CC_HARD]  = onboard_slave_hard_reset_in;
        read_value[BRC_CC_SOFT]  = onboard_slave_soft_reset_in;
      end
      BRC_IDX_CLK_BOOT: begin
        read_value = clk_boot_reg;
        read_value[BRC_CB_DEBUG] = slave_debug_input_in;
      end
      default: begin
        read_value = BRC_UNMAPPED_READ;
      end
    endcase
  end

  // Bus answer: one acknowledge the cycle after the access is taken
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      busy_reg      <= 1'b0;
      ta_n_out      <= 1'b1;
      data_out      <= 8'h00;
      data_oe_n_out <= 1'b1;
    end else if (ce_in) begin
      ta_n_out      <= !access;
      data_oe_n_out <= !(access && rd_wr_in);
      if (access && rd_wr_in) begin
        data_out <= read_value;
      end
      if (access) begin
        busy_reg <= 1'b1;
      end else if (cs_n_in) begin
        busy_reg <= 1'b0;
      end
    end
  end

endmodule : brc_regs

// ==== verif/brc_regs_assertions.sv ====
// Port-level checks for the board reset register bank
`timescale 1ns/1ns
module brc_regs_checker #(
  parameter int REQ_CYCLES  = 2,
  parameter int HOLD_CYCLES = 2
) (
  input wire logic       clk_sys_in,
  input wire logic       sys_rst_in,
  input wire logic       ce_in,
  input wire logic       cs_n_in,
  input wire logic       rd_wr_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] data_in,
  input wire logic       ta_n_out,
  input wire logic       data_oe_n_out,
  input wire logic       hard_reset_line_n_in,
  input wire logic       host_phy_reset_n_out,
  input wire logic       slave_config_request_line_n_out,
  input wire logic [2:0] slave_boot_mode_oe_n_out,
  input wire logic       slave_debug_input_out,
  input wire logic       slave_debug_input_oe_n_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  logic [7:0] low_cnt_reg;
  wire        wr_req = ce_in && !cs_n_in && !rd_wr_in;
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || slave_config_request_line_n_out) low_cnt_reg <= 8'h00;
    else low_cnt_reg <= low_cnt_reg + 8'h01;
  end
  a_ack_one_cycle: assert property (!ta_n_out |=> ta_n_out)
    else $error("ack too long");
  a_ack_after_take: assert property ($fell(cs_n_in) && ce_in |=> !ta_n_out)
    else $error("ack missing");
  a_read_drives_bus: assert property (
    !ta_n_out |-> data_oe_n_out == !$past(rd_wr_in))
    else $error("data drive wrong");
  a_phy_hard_reset: assert property (
    !hard_reset_line_n_in |=> !host_phy_reset_n_out)
    else $error("phy reset missing");
  a_slave_reconfig_request_start: assert property (
    $fell(cs_n_in) && wr_req && addr_in == 3'h1 && !data_in[0]
    |=> !slave_config_request_line_n_out)
    else $error("request missing");
  a_request_length: assert property (
    $rose(slave_config_request_line_n_out) |-> low_cnt_reg == REQ_CYCLES)
    else $error("request length wrong");
  a_pins_float: assert property (
    $rose(slave_config_request_line_n_out)
    |-> slave_boot_mode_oe_n_out == 3'h0 ##HOLD_CYCLES slave_boot_mode_oe_n_out == 3'h7)
    else $error("pins not released");
  // Pulse length matches the bench setting of two cycles
  a_debug_pulse: assert property (
    $fell(cs_n_in) && wr_req && addr_in == 3'h3 && !data_in[2]
    |=> (slave_debug_input_out && !slave_debug_input_oe_n_out) [*2]
    ##1 slave_debug_input_oe_n_out)
    else $error("debug pulse wrong");
  cover property ($fell(cs_n_in) && rd_wr_in);
  cover property ($rose(slave_config_request_line_n_out));
  cover property (!slave_debug_input_oe_n_out);
endmodule : brc_regs_checker
bind brc_regs brc_regs_checker #(.REQ_CYCLES(REQ_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) u_chk (.*);

// ==== verif/brc_host_model.sv ====
// Host bus master issuing single-byte register accesses
`timescale 1ns/1ns
module brc_host_model (
  input  wire logic       clk_sys_in,
  input  wire logic       ta_n_in,
  input  wire logic [7:0] rdata_in,
  output logic            cs_n_out = 1'b1,
  output logic            rd_wr_out = 1'b1,
  output logic      [2:0] addr_out = 3'h0,
  output logic      [7:0] wdata_out = 8'h00
);
  // Request held until the acknowledge cycle
  task automatic access(input logic rw, input logic [2:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clk_sys_in);
    cs_n_out  <= 1'b0;
    rd_wr_out <= rw;
    addr_out  <= a;
    wdata_out <= d;
    // Acknowledge and read byte taken at one rising edge; a hang is the watchdog's
    do begin
      @(posedge clk_sys_in);
    end while (ta_n_in !== 1'b0);
    q = rdata_in;
    cs_n_out  <= 1'b1;
    // Released lines must not keep showing the last value
    addr_out  <= ~a;
    wdata_out <= ~d;
    @(negedge clk_sys_in);
  endtask : access
endmodule : brc_host_model

// ==== verif/brc_regs_tb.sv ====
// Self-checking bench for the board reset register bank
`timescale 1ns/1ns
module brc_regs_tb import brc_pkg::*;;
  localparam int REQ = 2, HOLD = 2;
  int n_errors = 0, n_compared = 0;
  logic clk_sys_in = 1'b0, sys_rst_in = 1'b1, ce_in = 1'b1, hard_reset_line_n_in = 1'b1;
  logic cfg_switch_on_in = 1'b1, host_if_width_switch_in = 1'b1, cs_n_in, rd_wr_in;
  logic [1:0] clock_mode_switch_in = 2'h2, slave_clock_mode_out, slave_clock_mode_oe_n_out;
  logic [2:0] addr_in, offboard_slave_hard_reset_in, offboard_slave_hard_reset_out;
  logic [2:0] offboard_slave_hard_reset_oe_n_out, slave_boot_mode_out, slave_boot_mode_oe_n_out;
  logic [7:0] data_in, data_out;
  logic data_oe_n_out, ta_n_out, host_phy_reset_n_out, host_serial_xcvr_enable_n_out;
  logic onboard_slave_hard_reset_in, onboard_slave_hard_reset_out;
  logic onboard_slave_hard_reset_oe_n_out, onboard_slave_soft_reset_in;
  logic onboard_slave_soft_reset_out, onboard_slave_soft_reset_oe_n_out;
  logic slave_uart_xcvr_enable_n_out, framer_route_select_out, slave_config_request_line_n_out;
  logic slave_reset_config_mode_out, slave_config_source_out, slave_config_source_oe_n_out;
  logic slave_watchdog_enable_out, slave_watchdog_enable_oe_n_out, host_if_sync_mode_out;
  logic host_if_sync_mode_oe_n_out, slave_debug_input_in, slave_debug_input_out;
  logic slave_debug_input_oe_n_out;
  // Reset lines pulled up, debug line pulled down
  assign offboard_slave_hard_reset_in = offboard_slave_hard_reset_oe_n_out
                                      | offboard_slave_hard_reset_out;
  assign onboard_slave_hard_reset_in = onboard_slave_hard_reset_oe_n_out
                                     | onboard_slave_hard_reset_out;
  assign onboard_slave_soft_reset_in = onboard_slave_soft_reset_oe_n_out
                                     | onboard_slave_soft_reset_out;
  assign slave_debug_input_in = !slave_debug_input_oe_n_out & slave_debug_input_out;
  brc_regs #(.REQ_CYCLES(REQ), .HOLD_CYCLES(HOLD), .DEBUG_CYCLES(2)) DUT (.*);
  brc_host_model host (.clk_sys_in(clk_sys_in), .ta_n_in(ta_n_out), .rdata_in(data_out),
    .cs_n_out(cs_n_in), .rd_wr_out(rd_wr_in), .addr_out(addr_in), .wdata_out(data_in));
  always #20 clk_sys_in = ~clk_sys_in;
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] v;
    host.access(1'b0, a, d, v);
  endtask : wr
  task automatic rc(input string nm, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.access(1'b1, a, 8'h00, v);
    chk(nm, v, exp);
  endtask : rc
  task automatic t_defaults;
    rc("rst_ctrl", 3'h1, BRC_RST_CTRL_DEFAULT);
    rc("cfg_ctrl", 3'h2, 8'he8);
    rc("clk_boot", 3'h3, 8'h9a);
    rc("unmapped0", 3'h0, BRC_UNMAPPED_READ);
    rc("unmapped7", 3'h7, BRC_UNMAPPED_READ);
    chk("xcvr", {5'h0, host_phy_reset_n_out, host_serial_xcvr_enable_n_out,
      slave_uart_xcvr_enable_n_out}, 8'h06);
    $display("done defaults");
  endtask : t_defaults
  task automatic t_resets;
    wr(3'h1, 8'h00);
    rc("rst_low", 3'h1, 8'h09);
    chk("rst_on", {1'b0, offboard_slave_hard_reset_oe_n_out, 1'b0, host_phy_reset_n_out,
      host_serial_xcvr_enable_n_out, slave_uart_xcvr_enable_n_out}, 8'h00);
    wr(3'h1, 8'hff);
    rc("rst_high", 3'h1, 8'hff);
    chk("rst_off", {1'b0, offboard_slave_hard_reset_oe_n_out, 1'b0, host_phy_reset_n_out,
      host_serial_xcvr_enable_n_out, slave_uart_xcvr_enable_n_out}, 8'h77);
    $display("done resets");
  endtask : t_resets
  task automatic t_cfg;
    wr(3'h2, 8'h17);
    rc("cfg_wr", 3'h2, 8'h1f);
    chk("cfg_pins", {4'h0, framer_route_select_out, onboard_slave_hard_reset_oe_n_out,
      onboard_slave_soft_reset_oe_n_out, slave_reset_config_mode_out}, 8'h01);
    wr(3'h1, 8'hfe);
    chk("cfg_drive", {2'h0, slave_config_source_out, slave_config_source_oe_n_out,
      slave_watchdog_enable_out, slave_watchdog_enable_oe_n_out, host_if_sync_mode_out,
      host_if_sync_mode_oe_n_out}, 8'h2a);
    repeat (REQ + HOLD) @(negedge clk_sys_in);
    chk("cfg_float", {5'h0, slave_config_source_oe_n_out, slave_watchdog_enable_oe_n_out,
      host_if_sync_mode_oe_n_out}, 8'h07);
    $display("done cfg");
  endtask : t_cfg
  task automatic t_boot;
    wr(3'h3, 8'h21);
    chk("debug", {6'h0, slave_debug_input_out, slave_debug_input_oe_n_out}, 8'h02);
    rc("cb_wr", 3'h3, 8'h39);
    wr(3'h1, 8'hfe);
    chk("boot", {slave_clock_mode_out, slave_clock_mode_oe_n_out, 1'b0,
      slave_boot_mode_out}, 8'h41);
    $display("done boot");
  endtask : t_boot
  task automatic t_hard;
    wr(3'h1, 8'hbf);
    wr(3'h3, 8'h9f);
    @(posedge clk_sys_in);
    hard_reset_line_n_in <= 1'b0;
    // Switch off, so the reload must pick the other default set
    cfg_switch_on_in     <= 1'b0;
    repeat (2) @(negedge clk_sys_in);
    chk("phy_hard", {7'h0, host_phy_reset_n_out}, 8'h00);
    @(posedge clk_sys_in);
    hard_reset_line_n_in <= 1'b1;
    rc("rst_reload", 3'h1, BRC_RST_CTRL_DEFAULT);
    rc("cfg_reload", 3'h2, 8'hee);
    rc("cb_reload", 3'h3, 8'h1a);
    $display("done hard reset");
  endtask : t_hard
  task automatic complete_run;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    #(40 * 2000);
    n_errors++;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    t_defaults;
    t_resets;
    t_cfg;
    t_boot;
    t_hard;
    complete_run;
  end
endmodule : brc_regs_tb
